// ### raw_alarm_wdog.sv
`timescale 1ns/10ps
`default_nettype none
module raw_alarm_wdog (
    input  wire logic             sys_clk_i,
    input  wire logic             reset_i,
    input  wire raw_pkg::raw_acc_t acc_i,
    input  wire logic [5:0]       ptr_i,
    output logic [7:0]            rdata_o,
    input  wire raw_pkg::raw_time_t now_i,
    input  wire logic             sec_tick_i,
    input  wire logic             osc_level_i,
    input  wire logic             backup_mode_i,
    input  wire logic             recovery_length_select_i,
    input  wire logic             watchdog_kick_pin_i,
    output logic                  interrupt_test_out_pin_o,
    output logic                  interrupt_test_out_pin_oe_o,
    output logic                  reset_pin_o,
    output logic                  reset_pin_oe_o,
    output logic                  square_wave_pin_o
);
    import raw_pkg::*;

    // ****************************************
    // Helpers
    // ****************************************
    function automatic logic alarm_hit(input logic [4:0] code, input raw_time_t t, input raw_time_t a);
        logic s;
        logic m;
        logic h;
        logic d;
        logic mo;
        s  = t.second[6:0] == a.second[6:0];
        m  = t.minute[6:0] == a.minute[6:0];
        h  = t.hour[5:0]   == a.hour[5:0];
        d  = t.date[5:0]   == a.date[5:0];
        mo = t.month[4:0]  == a.month[4:0];
        case (code)
            RPT_MINUTE: alarm_hit = s;
            RPT_HOUR:   alarm_hit = s & m;
            RPT_DAY:    alarm_hit = s & m & h;
            RPT_MONTH:  alarm_hit = s & m & h & d;
            RPT_YEAR:   alarm_hit = s & m & h & d & mo;
            default:    alarm_hit = 1'b1;
        endcase
    endfunction : alarm_hit

    function automatic logic [21:0] wd_limit(input logic [7:0] wd);
        wd_limit = 22'(wd[6:2]) * (WD_BASE_TICKS << {wd[1:0], 1'b0});
    endfunction : wd_limit

    // ****************************************
    // Registers
    // ****************************************
    logic [7:0]  control_reg;
    logic [7:0]  wdog_reg;
    logic [7:0]  al_month_reg;
    logic [7:0]  al_date_reg;
    logic [7:0]  al_hour_reg;
    logic [7:0]  al_min_reg;
    logic [7:0]  al_sec_reg;
    logic [7:0]  sqw_sel_reg;
    logic        alarm_flag_reg;
    logic        alarm_pend_reg;
    logic        wdog_flag_reg;
    logic        wd_irq_reg;
    logic [21:0] wd_cnt_reg;
    logic        osc_prev_reg;
    logic        kick_prev_reg;
    logic [14:0] div_reg;
    logic [11:0] rec_cnt_reg;
    logic        rst_act_reg;
    logic        pin_low_reg;
    logic        sqw_reg;

    logic        osc_tick;
    logic        kick_edge;
    logic        wr_wdog;
    logic        rd_flags;
    logic        alarm_match;
    logic        wd_run;
    logic        wd_timeout;
    logic        wd_to_rst;
    logic [4:0]  rpt_code;
    raw_time_t   al_set;

    assign osc_tick    = osc_level_i & ~osc_prev_reg;
    assign kick_edge   = watchdog_kick_pin_i ^ kick_prev_reg;
    assign wr_wdog     = acc_i.wr && acc_i.addr == ADDR_WATCHDOG;
    assign rd_flags    = acc_i.rd && acc_i.addr == ADDR_FLAGS;
    assign rpt_code    = {al_date_reg[BIT_REPEAT_SEL_BIT5], al_date_reg[BIT_RPT_HI], al_hour_reg[BIT_RPT_HI],
                          al_min_reg[BIT_RPT_HI], al_sec_reg[BIT_RPT_HI]};
    assign al_set      = '{al_month_reg, al_date_reg, al_hour_reg, al_min_reg, al_sec_reg};
    assign alarm_match = sec_tick_i && alarm_hit(rpt_code, now_i, al_set);
    assign wd_run      = wdog_reg[6:2] != 5'h00 && !wd_irq_reg;
    assign wd_timeout  = wd_run && osc_tick && !wr_wdog && !kick_edge
                         && (wd_cnt_reg + 22'h000001) >= wd_limit(wdog_reg);
    assign wd_to_rst   = wd_timeout && wdog_reg[BIT_WDS];

    // ****************************************
    // Edge samplers and divider
    // ****************************************
    always_ff @(posedge sys_clk_i or posedge reset_i) begin
        if (reset_i) begin
            osc_prev_reg  <= 1'b0;
            kick_prev_reg <= 1'b0;
            div_reg       <= 15'h0000;
        end else begin
            osc_prev_reg  <= osc_level_i;
            kick_prev_reg <= watchdog_kick_pin_i;
            if (osc_tick) begin
                div_reg <= div_reg + 15'h0001;
            end
        end
    end

    // ****************************************
    // Host writes
    // ****************************************
    always_ff @(posedge sys_clk_i or posedge reset_i) begin
        if (reset_i) begin
            control_reg  <= RST_CONTROL;
            wdog_reg     <= RST_WATCHDOG;
            al_month_reg <= RST_AL_MONTH;
            al_date_reg  <= RST_ZERO;
            al_hour_reg  <= RST_ZERO;
            al_min_reg   <= RST_ZERO;
            al_sec_reg   <= RST_ZERO;
            sqw_sel_reg  <= RST_ZERO;
        end else if (wd_to_rst) begin
            wdog_reg                  <= RST_WATCHDOG;
            control_reg[BIT_FT]       <= 1'b0;
            al_month_reg[BIT_AFE]     <= 1'b0;
            al_month_reg[BIT_ABE]     <= 1'b0;
            al_month_reg[BIT_SQUARE_WAVE_ENABLE]    <= 1'b0;
        end else if (acc_i.wr) begin
            case (acc_i.addr)
                ADDR_CONTROL:  control_reg  <= acc_i.wdata;
                ADDR_WATCHDOG: wdog_reg     <= acc_i.wdata;
                ADDR_AL_MONTH: al_month_reg <= acc_i.wdata;
                ADDR_AL_DATE:  al_date_reg  <= acc_i.wdata;
                ADDR_AL_HOUR:  al_hour_reg  <= acc_i.wdata;
                ADDR_AL_MIN:   al_min_reg   <= acc_i.wdata;
                ADDR_AL_SEC:   al_sec_reg   <= acc_i.wdata;
                ADDR_SQW:      sqw_sel_reg  <= {acc_i.wdata[7:4], 4'h0};
                default:       ;
            endcase
        end
    end

    // ****************************************
    // Host reads
    // ****************************************
    always_ff @(posedge sys_clk_i or posedge reset_i) begin
        if (reset_i) begin
            rdata_o <= 8'h00;
        end else if (acc_i.rd) begin
            case (acc_i.addr)
                ADDR_CONTROL:  rdata_o <= control_reg;
                ADDR_WATCHDOG: rdata_o <= wdog_reg;
                ADDR_AL_MONTH: rdata_o <= al_month_reg;
                ADDR_AL_DATE:  rdata_o <= al_date_reg;
                ADDR_AL_HOUR:  rdata_o <= al_hour_reg;
                ADDR_AL_MIN:   rdata_o <= al_min_reg;
                ADDR_AL_SEC:   rdata_o <= al_sec_reg;
                ADDR_FLAGS:    rdata_o <= {wdog_flag_reg, alarm_flag_reg, 6'h00};
                ADDR_SQW:      rdata_o <= sqw_sel_reg;
                default:       rdata_o <= 8'h00;
            endcase
        end
    end

    // ****************************************
    // Alarm flag
    // ****************************************
    always_ff @(posedge sys_clk_i or posedge reset_i) begin
        if (reset_i) begin
            alarm_flag_reg <= 1'b0;
            alarm_pend_reg <= 1'b0;
        end else begin
            if (ptr_i == ADDR_FLAGS) begin
                alarm_pend_reg <= alarm_pend_reg | alarm_match;
            end else begin
                alarm_pend_reg <= 1'b0;
            end
            if ((alarm_match || alarm_pend_reg) && ptr_i != ADDR_FLAGS) begin
                alarm_flag_reg <= 1'b1;
            end else if (rd_flags) begin
                alarm_flag_reg <= 1'b0;
            end
        end
    end

    // ****************************************
    // Watchdog
    // ****************************************
    always_ff @(posedge sys_clk_i or posedge reset_i) begin
        if (reset_i) begin
            wd_cnt_reg    <= 22'h000000;
            wd_irq_reg    <= 1'b0;
            wdog_flag_reg <= 1'b0;
        end else begin
            if (wr_wdog || kick_edge || !wd_run || wd_timeout) begin
                wd_cnt_reg <= 22'h000000;
            end else if (osc_tick) begin
                wd_cnt_reg <= wd_cnt_reg + 22'h000001;
            end
            if (wd_timeout) begin
                wdog_flag_reg <= 1'b1;
            end else if (rd_flags) begin
                wdog_flag_reg <= 1'b0;
            end
            if (wd_timeout && !wdog_reg[BIT_WDS]) begin
                wd_irq_reg <= 1'b1;
            end else if (wr_wdog && acc_i.wdata == 8'h00) begin
                wd_irq_reg <= 1'b0;
            end
        end
    end

    // ****************************************
    // Reset pulse
    // ****************************************
    always_ff @(posedge sys_clk_i or posedge reset_i) begin
        if (reset_i) begin
            rst_act_reg <= 1'b0;
            rec_cnt_reg <= 12'h000;
        end else if (wd_to_rst) begin
            rst_act_reg <= 1'b1;
            rec_cnt_reg <= recovery_length_select_i ? REC_SHORT_TICKS : REC_LONG_TICKS;
        end else if (rst_act_reg && osc_tick) begin
            if (rec_cnt_reg == 12'h001) begin
                rst_act_reg <= 1'b0;
            end
            rec_cnt_reg <= rec_cnt_reg - 12'h001;
        end
    end

    // ****************************************
    // Interrupt, test and output pin
    // ****************************************
    logic pin_low_next;
    logic wd_owns_pin;
    logic alarm_irq;
    logic ft_active;

    always_comb begin
        wd_owns_pin = wdog_reg != 8'h00 && !wdog_reg[BIT_WDS];
        alarm_irq   = alarm_flag_reg && al_month_reg[BIT_AFE];
        ft_active   = control_reg[BIT_FT] && !al_month_reg[BIT_AFE] && !wd_owns_pin;
        if (backup_mode_i) begin
            pin_low_next = alarm_irq && al_month_reg[BIT_ABE];
        end else if (wd_irq_reg || alarm_irq) begin
            pin_low_next = 1'b1;
        end else if (ft_active) begin
            pin_low_next = !div_reg[FT_DIV_BIT];
        end else if (!control_reg[BIT_FT] && !al_month_reg[BIT_AFE] && wdog_reg == 8'h00) begin
            pin_low_next = !control_reg[BIT_OUT];
        end else begin
            pin_low_next = 1'b0;
        end
    end

    always_ff @(posedge sys_clk_i or posedge reset_i) begin
        if (reset_i) begin
            pin_low_reg <= 1'b0;
        end else begin
            pin_low_reg <= pin_low_next;
        end
    end

    assign interrupt_test_out_pin_o    = 1'b0;
    assign interrupt_test_out_pin_oe_o = pin_low_reg;
    assign reset_pin_o                 = 1'b0;
    assign reset_pin_oe_o              = rst_act_reg;

    // ****************************************
    // Square wave
    // ****************************************
    logic [3:0] rate_sel;
    assign rate_sel = sqw_sel_reg[7:4];

    always_ff @(posedge sys_clk_i or posedge reset_i) begin
        if (reset_i) begin
            sqw_reg <= 1'b0;
        end else if (!al_month_reg[BIT_SQUARE_WAVE_ENABLE] || rate_sel == 4'h0) begin
            sqw_reg <= 1'b0;
        end else if (rate_sel == 4'h1) begin
            sqw_reg <= osc_level_i;
        end else begin
            sqw_reg <= div_reg[rate_sel - 4'h1];
        end
    end

    assign square_wave_pin_o = sqw_reg;

    // ****************************************
    // Checks
    // ****************************************
    chk_flag_read_clear: assert property (@(posedge sys_clk_i) disable iff (reset_i)
        rd_flags && !wd_timeout |=> !wdog_flag_reg)
        else $error("watchdog flag not cleared by flags read");
    chk_wd_flag_set: assert property (@(posedge sys_clk_i) disable iff (reset_i)
        wd_timeout |=> wdog_flag_reg)
        else $error("watchdog flag not set on timeout");
    chk_alarm_hold: assert property (@(posedge sys_clk_i) disable iff (reset_i)
        ptr_i == ADDR_FLAGS && !alarm_flag_reg && !rd_flags |=> !alarm_flag_reg)
        else $error("alarm flag set while pointer on flags");
    chk_alarm_set: assert property (@(posedge sys_clk_i) disable iff (reset_i)
        alarm_match && ptr_i != ADDR_FLAGS |=> alarm_flag_reg)
        else $error("alarm match did not set flag");
    chk_rst_clears: assert property (@(posedge sys_clk_i) disable iff (reset_i)
        wd_to_rst |=> wdog_reg == 8'h00 && !control_reg[BIT_FT] && !al_month_reg[BIT_AFE]
                      && !al_month_reg[BIT_ABE] && !al_month_reg[BIT_SQUARE_WAVE_ENABLE] && reset_pin_oe_o)
        else $error("reset timeout did not clear enables");
    chk_irq_release: assert property (@(posedge sys_clk_i) disable iff (reset_i)
        wd_irq_reg && wr_wdog && acc_i.wdata == 8'h00 |=> !wd_irq_reg ##1 !wd_run)
        else $error("watchdog interrupt not released by 00h");
    chk_pin_wd: assert property (@(posedge sys_clk_i) disable iff (reset_i)
        wd_irq_reg && !backup_mode_i |=> interrupt_test_out_pin_oe_o)
        else $error("watchdog interrupt lost on pin");
    chk_backup_gate: assert property (@(posedge sys_clk_i) disable iff (reset_i)
        backup_mode_i && !al_month_reg[BIT_ABE] |=> !interrupt_test_out_pin_oe_o)
        else $error("pin driven in backup without enable");
    chk_sqw_off: assert property (@(posedge sys_clk_i) disable iff (reset_i)
        !al_month_reg[BIT_SQUARE_WAVE_ENABLE] |=> !square_wave_pin_o)
        else $error("square wave active while disabled");
    chk_kick_restart: assert property (@(posedge sys_clk_i) disable iff (reset_i)
        kick_edge |=> wd_cnt_reg == 22'h000000)
        else $error("kick edge did not restart watchdog");

    cov_alarm_irq:  cover property (@(posedge sys_clk_i) disable iff (reset_i) alarm_irq ##1 rd_flags);
    cov_wd_rst:     cover property (@(posedge sys_clk_i) disable iff (reset_i) wd_to_rst);
    cov_wd_irq:     cover property (@(posedge sys_clk_i) disable iff (reset_i) wd_timeout && !wd_to_rst);
    cov_sqw_toggle: cover property (@(posedge sys_clk_i) disable iff (reset_i) $rose(square_wave_pin_o));

endmodule : raw_alarm_wdog
`default_nettype wire

// ### raw_host_model.sv
`timescale 1ns/10ps
`default_nettype none
// ****************************************
// Host side of the register port
// ****************************************
module raw_host_model (
    input  wire logic            sys_clk_i,
    input  wire logic [7:0]      rdata_i,
    output var raw_pkg::raw_acc_t acc_o,
    output logic [5:0]           ptr_o
);
    import raw_pkg::*;

    initial begin
        acc_o = '0;
        ptr_o = 6'h00;
    end

    // One access, held over one sampling edge
    task automatic xfer(input logic w, input logic [5:0] a, input logic [7:0] d, output logic [7:0] q);
        @(posedge sys_clk_i);
        #1;
        acc_o = '{rd: ~w, wr: w, addr: a, wdata: d};
        ptr_o = a;
        @(posedge sys_clk_i);
        #1;
        q = rdata_i;
        acc_o = '{rd: 1'b0, wr: 1'b0, addr: ~a, wdata: ~d};
        ptr_o = a + 6'h01;
    endtask : xfer

    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        logic [7:0] q;
        xfer(1'b1, a, d, q);
    endtask : wr

    task automatic rd(input logic [5:0] a, output logic [7:0] q);
        xfer(1'b0, a, 8'h00, q);
    endtask : rd

    task automatic move(input logic [5:0] a);
        @(posedge sys_clk_i);
        #1;
        ptr_o = a;
    endtask : move

    // Zero date and all repeat bits
    task automatic alarm_off();
        wr(ADDR_AL_DATE, 8'h00);
        wr(ADDR_AL_HOUR, 8'h00);
        wr(ADDR_AL_MIN, 8'h00);
        wr(ADDR_AL_SEC, 8'h00);
    endtask : alarm_off
endmodule : raw_host_model
`default_nettype wire

// ### raw_pkg.sv
// Functional notes
// - Repeat bits pick second..year alarm match
// - Undefined repeat codes act as every second
// - Alarm match sets alarm flag at 0Fh
// - Enabled alarm flag pulls interrupt pin low
// - Pointer on flags address holds alarm off
// - Flags read releases pin, later read shows
// - Backup alarm needs backup and flag enables
// - Power-up clears backup and flag enables
// - Two low watchdog bits select resolution
// - Timeout is multiplier times resolution
// - Missed restart sets flag, interrupt or reset
// - Flags read clears watchdog flag D7
// - Steering bit picks interrupt or reset pulse
// - Reset-steered timeout clears enables and watchdog
// - Kick pin edge or write restarts watchdog
// - Writing 00h releases pin, disables watchdog
// - Power-up clears watchdog register
// - Watchdog interrupt beats frequency test output
// - Rate select picks square wave frequency
// - Square wave only while enable set
// - Recovery bit sets reset pulse length
// - Timing derives from 32768 Hz oscillator
package raw_pkg;

    // ****************************************
    // Register addresses
    // ****************************************
    localparam logic [5:0] ADDR_CONTROL    = 6'h08;
    localparam logic [5:0] ADDR_WATCHDOG   = 6'h09;
    localparam logic [5:0] ADDR_AL_MONTH   = 6'h0A;
    localparam logic [5:0] ADDR_AL_DATE    = 6'h0B;
    localparam logic [5:0] ADDR_AL_HOUR    = 6'h0C;
    localparam logic [5:0] ADDR_AL_MIN     = 6'h0D;
    localparam logic [5:0] ADDR_AL_SEC     = 6'h0E;
    localparam logic [5:0] ADDR_FLAGS      = 6'h0F;
    localparam logic [5:0] ADDR_SQW        = 6'h13;

    // ****************************************
    // Field positions
    // ****************************************
    localparam int BIT_OUT           = 7;
    localparam int BIT_FT            = 6;
    localparam int BIT_WDS           = 7;
    localparam int BIT_AFE           = 7;
    localparam int BIT_SQUARE_WAVE_ENABLE          = 6;
    localparam int BIT_ABE           = 5;
    localparam int BIT_WDF           = 7;
    localparam int BIT_AF            = 6;
    localparam int BIT_RPT_HI        = 7;
    localparam int BIT_REPEAT_SEL_BIT5          = 6;

    // ****************************************
    // Reset values
    // ****************************************
    localparam logic [7:0] RST_CONTROL   = 8'h80;
    localparam logic [7:0] RST_WATCHDOG  = 8'h00;
    localparam logic [7:0] RST_AL_MONTH  = 8'h00;
    localparam logic [7:0] RST_ZERO      = 8'h00;

    // ****************************************
    // Repeat codes
    // ****************************************
    localparam logic [4:0] RPT_SECOND = 5'h1F;
    localparam logic [4:0] RPT_MINUTE = 5'h1E;
    localparam logic [4:0] RPT_HOUR   = 5'h1C;
    localparam logic [4:0] RPT_DAY    = 5'h18;
    localparam logic [4:0] RPT_MONTH  = 5'h10;
    localparam logic [4:0] RPT_YEAR   = 5'h00;

    // ****************************************
    // Timing
    // ****************************************
    localparam int         OSC_HZ          = 32768;
    localparam int         REC_LONG_MS     = 97;
    localparam int         REC_SHORT_US    = 1000;
    localparam logic [11:0] REC_LONG_TICKS = 12'(REC_LONG_MS * OSC_HZ / 1000);
    localparam logic [11:0] REC_SHORT_TICKS = 12'(REC_SHORT_US * OSC_HZ / 1000000);
    localparam logic [21:0] WD_BASE_TICKS  = 22'(OSC_HZ / 16);
    localparam int         FT_DIV_BIT      = 5;

    // ****************************************
    // Carriers
    // ****************************************
    typedef struct packed {
        logic [7:0] month;
        logic [7:0] date;
        logic [7:0] hour;
        logic [7:0] minute;
        logic [7:0] second;
    } raw_time_t;

    typedef struct packed {
        logic       rd;
        logic       wr;
        logic [5:0] addr;
        logic [7:0] wdata;
    } raw_acc_t;

endpackage : raw_pkg

// ### tb_top.sv
`timescale 1ns/10ps
`default_nettype none
`define CHK(got, exp) begin total_checks++; if ((got) !== (exp)) begin n_errors++; $display("[ERR] t=%0t got=%0h exp=%0h", $time, got, exp); end end
module tb_top;
    import raw_pkg::*;
    logic       sys_clk = 1'b0, reset = 1'b1, sec_tick = 1'b0, osc_level = 1'b0;
    logic       backup_mode = 1'b0, rec_sel = 1'b0, kick = 1'b0, abe, hit;
    logic       irq_o, irq_oe, rst_o, rst_oe, square_wave_select;
    logic [5:0] ptr;
    logic [4:0] code;
    logic [7:0] d;
    raw_acc_t   acc;
    raw_time_t  al, now = '0;
    int         n_errors = 0, total_checks = 0, n, e, a, b;
    int         seed = int'(32'hB5CDBEAD);
    logic [4:0] codes [6] = '{RPT_SECOND, RPT_MINUTE, RPT_HOUR, RPT_DAY, RPT_MONTH, RPT_YEAR};
    logic [7:0] wd_cfg [3] = '{8'h04, 8'h05, 8'h0C};
    logic [5:0] rst_addr [4] = '{ADDR_WATCHDOG, ADDR_AL_MONTH, ADDR_FLAGS, ADDR_SQW};

    always #2.5 sys_clk = ~sys_clk;
    always @(posedge sys_clk) osc_level <= #1 ~osc_level;

    logic [7:0] d_bus;
    raw_host_model host (.sys_clk_i(sys_clk), .rdata_i(d_bus), .acc_o(acc), .ptr_o(ptr));
    raw_alarm_wdog dut (
        .sys_clk_i(sys_clk), .reset_i(reset), .acc_i(acc), .ptr_i(ptr), .rdata_o(d_bus),
        .now_i(now), .sec_tick_i(sec_tick), .osc_level_i(osc_level), .backup_mode_i(backup_mode),
        .recovery_length_select_i(rec_sel), .watchdog_kick_pin_i(kick),
        .interrupt_test_out_pin_o(irq_o), .interrupt_test_out_pin_oe_o(irq_oe),
        .reset_pin_o(rst_o), .reset_pin_oe_o(rst_oe), .square_wave_pin_o(square_wave_select));

    task automatic cyc(input int k);
        repeat (k) @(posedge sys_clk);
        #1;
    endtask : cyc

    task automatic hold(ref logic s, input logic v, input int lim, output int k);
        k = 0;
        while (s === v && k < lim) begin
            cyc(1);
            k++;
        end
    endtask : hold

    function automatic logic exp_hit(logic [4:0] c, raw_time_t x, raw_time_t t);
        int lvl;
        lvl = (c == RPT_MINUTE) ? 1 : (c == RPT_HOUR) ? 2 : (c == RPT_DAY) ? 3 :
              (c == RPT_MONTH) ? 4 : (c == RPT_YEAR) ? 5 : 0;
        exp_hit = 1'b1;
        for (int i = 0; i < lvl; i++) begin
            if (x[i*8 +: 8] !== t[i*8 +: 8]) exp_hit = 1'b0;
        end
    endfunction : exp_hit

    task automatic report_and_stop();
        $display("checks=%0d mismatches=%0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : report_and_stop

    initial begin
        #450_000;
        n_errors++;
        report_and_stop();
    end

    initial begin
        cyc(8);
        reset = 1'b0;
        foreach (rst_addr[i]) begin
            host.rd(rst_addr[i], d);
            `CHK(d, 8'h00)
        end
        $display("reset values done");
        for (int i = 0; i < 24; i++) begin
            code = (i % 8 < 6) ? codes[i % 8] : 5'($random(seed));
            for (int f = 0; f < 5; f++) al[f*8 +: 8] = {3'h0, 5'($random(seed))};
            now = al;
            if ($random(seed) & 1) now[({$random(seed)} % 5)*8 +: 8] ^= 8'h01;
            hit = exp_hit(code, al, now);
            abe = 1'($random(seed));
            backup_mode = 1'($random(seed));
            host.wr(ADDR_AL_MONTH, {2'b10, abe, al.month[4:0]});
            host.wr(ADDR_AL_DATE, {code[3], code[4], al.date[5:0]});
            host.wr(ADDR_AL_HOUR, {code[2], 1'b0, al.hour[5:0]});
            host.wr(ADDR_AL_MIN, {code[1], al.minute[6:0]});
            host.wr(ADDR_AL_SEC, {code[0], al.second[6:0]});
            sec_tick = 1'b1;
            cyc(1);
            sec_tick = 1'b0;
            cyc(3);
            `CHK(irq_oe, 1'b0)
            host.move(6'h00);
            cyc(3);
            `CHK(irq_oe, hit & (~backup_mode | abe))
            `CHK(irq_o, 1'b0)
            host.rd(ADDR_FLAGS, d);
            `CHK(d, {1'b0, hit, 6'h00})
            cyc(2);
            `CHK(irq_oe, 1'b0)
            host.rd(ADDR_FLAGS, d);
            `CHK(d, 8'h00)
        end
        backup_mode = 1'b0;
        host.alarm_off();
        host.wr(ADDR_AL_MONTH, 8'h00);
        $display("alarm test done");
        foreach (wd_cfg[j]) begin
            host.wr(ADDR_WATCHDOG, wd_cfg[j]);
            host.wr(ADDR_CONTROL, 8'hC0);
            hold(irq_oe, 1'b0, 40000, n);
            e = int'(wd_cfg[j][6:2]) * (2048 << (2 * wd_cfg[j][1:0])) * 2;
            `CHK(n + 2 > e - 10 && n + 2 < e + 10, 1'b1)
            host.rd(ADDR_FLAGS, d);
            `CHK(d, 8'h80)
            cyc(2);
            `CHK(irq_oe, 1'b1)
            host.rd(ADDR_FLAGS, d);
            `CHK(d, 8'h00)
            host.wr(ADDR_CONTROL, 8'h80);
            host.wr(ADDR_WATCHDOG, 8'h00);
            cyc(2);
            `CHK(irq_oe, 1'b0)
        end
        $display("watchdog interrupt test done");
        host.wr(ADDR_WATCHDOG, 8'h04);
        cyc(3000);
        kick = 1'b1;
        cyc(3000);
        `CHK(irq_oe, 1'b0)
        host.wr(ADDR_WATCHDOG, 8'h04);
        cyc(3000);
        `CHK(irq_oe, 1'b0)
        cyc(1500);
        `CHK(irq_oe, 1'b1)
        host.wr(ADDR_WATCHDOG, 8'h00);
        host.rd(ADDR_FLAGS, d);
        host.wr(ADDR_CONTROL, 8'h40);
        cyc(2);
        hold(irq_oe, 1'b1, 200, n);
        hold(irq_oe, 1'b0, 200, n);
        hold(irq_oe, 1'b1, 200, a);
        hold(irq_oe, 1'b0, 200, b);
        `CHK(a + b, 128)
        $display("watchdog restart test done");
        for (int t = 0; t < 2; t++) begin
            rec_sel = t[0];
            host.wr(ADDR_AL_MONTH, 8'hE0);
            host.wr(ADDR_CONTROL, 8'hC0);
            host.wr(ADDR_WATCHDOG, 8'h84);
            hold(rst_oe, 1'b0, 6000, n);
            `CHK(rst_o, 1'b0)
            hold(rst_oe, 1'b1, 8000, n);
            e = 2 * int'(t ? REC_SHORT_TICKS : REC_LONG_TICKS);
            `CHK(n > e - 5 && n < e + 5, 1'b1)
            host.rd(ADDR_WATCHDOG, d);
            `CHK(d, 8'h00)
            host.rd(ADDR_AL_MONTH, d);
            `CHK(d, 8'h00)
            host.rd(ADDR_CONTROL, d);
            `CHK(d, 8'h80)
            host.rd(ADDR_FLAGS, d);
            `CHK(d, 8'h80)
        end
        $display("watchdog reset test done");
        host.wr(ADDR_AL_MONTH, 8'h40);
        for (int c = 0; c < 10; c++) begin
            if (c == 9) host.wr(ADDR_AL_MONTH, 8'h00);
            host.wr(ADDR_SQW, {4'(c % 9 == 0 ? 3 : c), 4'h0});
            cyc(4);
            hold(square_wave_select, 1'b1, 3000, n);
            hold(square_wave_select, 1'b0, 3000, n);
            hold(square_wave_select, 1'b1, 3000, a);
            hold(square_wave_select, 1'b0, 3000, b);
            e = (c == 0) ? (2 << 3) : (c == 9) ? 3000 : (c == 1) ? 2 : (2 << c);
            `CHK(a + b, e)
        end
        host.wr(ADDR_SQW, 8'h00);
        cyc(4);
        hold(square_wave_select, 1'b0, 3000, n);
        `CHK(n, 3000)
        $display("square wave test done");
        report_and_stop();
    end
endmodule : tb_top
`default_nettype wire
